// File: rtl/odp_pkg.sv
// package: register map, field layout, reset values and timing constants
package odp_pkg;
	localparam int ODP_NUM_OUT = 8;
	localparam logic [15:0] ODP_OUT_CFG = 16'h0000; // src[2:0], invert[3]
	localparam logic [15:0] ODP_DIV_CFG = 16'h0008; // first stage select [1:0]
	localparam logic [15:0] ODP_S2_LO = 16'h0010; // second stage half ratio lo
	localparam logic [15:0] ODP_S2_HI = 16'h0018; // second stage half ratio hi
	localparam logic [15:0] ODP_FRAC0 = 16'h0020; // n[17:0] then f[27:0]
	localparam logic [15:0] ODP_FRAC1 = 16'h0028;
	localparam logic [15:0] ODP_COARSE = 16'h0030; // steps, trigger, busy
	localparam logic [15:0] ODP_FINE = 16'h0038; // fine offset [3:0]
	localparam logic [15:0] ODP_MODE = 16'h003c; // hitless, slope rates
	localparam logic [15:0] ODP_RESYNC = 16'h00a8; // resync toggles [1:0]
	localparam int ODP_FRAC_BYTES = 7;
	// first stage encodings
	localparam logic [1:0] ODP_S1_DIV4 = 2'h0;
	localparam logic [1:0] ODP_S1_DIV5 = 2'h1;
	localparam logic [1:0] ODP_S1_DIV6 = 2'h2;
	localparam logic [1:0] ODP_S1_PASS = 2'h3;
	// source select encodings
	localparam logic [2:0] ODP_SRC_PLL_A = 3'h0;
	localparam logic [2:0] ODP_SRC_PLL_B = 3'h1;
	localparam logic [2:0] ODP_SRC_FRAC0 = 3'h2;
	localparam logic [2:0] ODP_SRC_FRAC1 = 3'h3;
	localparam logic [2:0] ODP_SRC_REF_A = 3'h4;
	localparam logic [2:0] ODP_SRC_REF_B = 3'h5;
	localparam logic [2:0] ODP_SRC_XTAL = 3'h6;
	// field positions
	localparam int ODP_INV_BIT = 3;
	localparam int ODP_TRIG_BIT = 6;
	localparam int ODP_BUSY_BIT = 7;
	// fractional limits
	localparam logic [17:0] ODP_N_MIN = 18'h00004;
	localparam logic [17:0] ODP_N_INT_MIN = 18'h00003;
	// coarse pacing: final gap count, four output periods between steps
	localparam logic [1:0] ODP_STEP_GAP = 2'h3;
	// reset values
	localparam logic [7:0] ODP_RST_OUT_CFG = 8'h00;
	localparam logic [7:0] ODP_RST_DIV_CFG = 8'h00;
	localparam logic [7:0] ODP_RST_BYTE = 8'h00;
	localparam logic [7:0] ODP_RST_N_LO = 8'h04;
	// settling window after lock or resync release
	localparam int ODP_CLK_MHZ = 50;
	localparam int ODP_SETTLE_NS = 350;
	localparam int ODP_SETTLE_CYC = (ODP_SETTLE_NS * ODP_CLK_MHZ + 999) / 1000;
	localparam logic [4:0] ODP_SETTLE_LOAD = 5'(ODP_SETTLE_CYC);
endpackage

// File: rtl/odp_int_div.sv
// two-stage integer output divider with one-tick period stretch
`timescale 1ns/1ps
`default_nettype none
module odp_int_div (
	input wire logic clk, // system clock
	input wire logic rst_b, // async reset, active low
	input wire logic tick, // source clock step
	input wire logic restart, // resync pulse
	input wire logic stretch, // lengthen one period by one step
	input wire logic [1:0] s1_sel, // first stage select
	input wire logic [15:0] s2_half, // second stage ratio / 2, 0 passes
	output logic lvl, // divided level
	output logic rise // rising edge pulse
);
	logic [2:0] cnt1;
	logic [15:0] cnt2;
	logic s2_lvl;
	logic skip;
	logic prev;
	wire pass1 = (s1_sel == odp_pkg::ODP_S1_PASS);
	wire [2:0] d1 = (s1_sel == odp_pkg::ODP_S1_DIV5) ? 3'h5 :
		(s1_sel == odp_pkg::ODP_S1_DIV6) ? 3'h6 : 3'h4;
	wire eff = tick & ~skip;
	wire wrap1 = pass1 ? eff : (eff && cnt1 == d1 - 3'h1);
	wire s1_lvl = pass1 ? tick : (cnt1 < {1'b0, d1[2:1]});
	wire wrap2 = wrap1 && cnt2 == s2_half - 16'h0001;
	wire next_lvl = (s2_half == 16'h0000) ? s1_lvl : s2_lvl;

	// first stage counter, stretch swallows one step
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt1 <= 3'h0;
			skip <= 1'b0;
		end else if (restart) begin
			cnt1 <= 3'h0;
			skip <= 1'b0;
		end else begin
			if (stretch)
				skip <= 1'b1;
			else if (tick)
				skip <= 1'b0;
			if (wrap1)
				cnt1 <= 3'h0;
			else if (eff)
				cnt1 <= cnt1 + 3'h1;
		end
	end

	// second stage: pass or even ratio up to 131070
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt2 <= 16'h0000;
			s2_lvl <= 1'b0;
		end else if (restart) begin
			cnt2 <= 16'h0000;
			s2_lvl <= 1'b0;
		end else if (wrap2) begin
			cnt2 <= 16'h0000;
			s2_lvl <= ~s2_lvl;
		end else if (wrap1) begin
			cnt2 <= cnt2 + 16'h0001;
		end
	end

	// registered level and edge
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			lvl <= 1'b0;
			prev <= 1'b0;
			rise <= 1'b0;
		end else begin
			lvl <= next_lvl;
			prev <= lvl;
			rise <= lvl & ~prev;
		end
	end
endmodule // odp_int_div
`default_nettype wire

// File: rtl/odp_top.sv
// output divider, source mapping and phase control block
// Behaviour
// - integer divider is two stages in series; first stage divides 4, 5 or 6.
// - second stage passes through or divides by even ratio 2 to 131070.
// - upper four integer outputs may pass the first stage through.
// - fractional dividers divide by twice N.F, N 4 to 2^18-1, 28-bit F.
// - with zero fraction the fractional divider also accepts N of three.
// - lower integer and fractional dividers pick first or second pll.
// - upper dividers pick either pll, fractional outputs, references, crystal.
// - per-pll mode bit picks hitless or slope-limited phase handling.
// - hitless keeps phase; it is withheld while external loopback is used.
// - slope limiting moves phase gradually at a two-bit per-pll rate.
// - only outputs sharing a source are aligned.
// - passed-through first stage has no coarse delay, leads by one step.
// - fractional outputs need no defined phase after power-up or resync.
// - upper divider sourced from fractional divider aligns to its output.
// - lock loss clears coarse phase; relock reloads fine phase.
// - toggling a pll resync bit resyncs and reloads all its outputs.
// - coarse request up to 31 steps, one stretch every four periods.
// - busy flag holds until coarse request completes; host then retriggers.
// - fine offset in sixteenths loads on resync toggle; output jumps there.
// - resync toggle clears all coarse delays on that pll's outputs.
// - every output has selectable inversion.
// - outputs may be unstable up to 350 ns after relock or resync.
`timescale 1ns/1ps
`default_nettype none
module odp_top (
	input wire logic clk, // 50 MHz system clock
	input wire logic rst_b, // async reset, active low
	input wire logic [15:0] reg_addr, // register address
	input wire logic [7:0] reg_wdata, // register write data
	input wire logic reg_wr, // register write strobe
	output logic [7:0] reg_rdata, // registered read data
	input wire logic first_pll_tick, // first pll step enable
	input wire logic second_pll_tick, // second pll step enable
	input wire logic reference_input_a_tick, // reference a step enable
	input wire logic reference_input_b_tick, // reference b step enable
	input wire logic xtal_tick, // crystal step enable
	input wire logic [1:0] loss_of_lock_flag, // per-pll unlock, async
	input wire logic ext_loopback, // external loopback in use
	output logic [7:0] out_clk, // divided, inverted outputs
	output logic [1:0] hitless_active, // hitless handling in force
	output logic [3:0] phase_slope_rate, // {second, first} slope rates
	output logic [1:0] output_settling // outputs may be unstable
);
	logic [7:0] out_cfg [8];
	logic [7:0] div_cfg [8];
	logic [7:0] s2_lo [8];
	logic [7:0] s2_hi [8];
	logic [7:0] frac_b [2][odp_pkg::ODP_FRAC_BYTES];
	logic [7:0] coarse [8];
	logic [3:0] fine [2];
	logic [5:0] mode_reg;
	logic [1:0] output_resync_trigger;
	logic [1:0] lol_m, lol_s, lol_d;
	logic [4:0] settle [2];
	logic [7:0] busy;
	logic [7:0] lvl, rise, stretch, restart;
	logic [1:0] frac_edge;
	logic [7:0] rd_val;

	// band decode shared by write and read paths
	function automatic logic in_band(input logic [15:0] a,
		input logic [15:0] base);
		in_band = (a[15:3] == base[15:3]);
	endfunction

	// pll owning a source: {mapped, pll index}
	function automatic logic [1:0] src_pll(input logic [2:0] src,
		input logic f0p, input logic f1p);
		case (src)
		odp_pkg::ODP_SRC_PLL_A: src_pll = 2'b10;
		odp_pkg::ODP_SRC_PLL_B: src_pll = 2'b11;
		odp_pkg::ODP_SRC_FRAC0: src_pll = {1'b1, f0p};
		odp_pkg::ODP_SRC_FRAC1: src_pll = {1'b1, f1p};
		default: src_pll = 2'b00;
		endcase
	endfunction

	wire [2:0] idx = reg_addr[2:0];
	wire wr_out = reg_wr & in_band(reg_addr, odp_pkg::ODP_OUT_CFG);
	wire wr_div = reg_wr & in_band(reg_addr, odp_pkg::ODP_DIV_CFG);
	wire wr_s2l = reg_wr & in_band(reg_addr, odp_pkg::ODP_S2_LO);
	wire wr_s2h = reg_wr & in_band(reg_addr, odp_pkg::ODP_S2_HI);
	wire wr_f0 = reg_wr & in_band(reg_addr, odp_pkg::ODP_FRAC0);
	wire wr_f1 = reg_wr & in_band(reg_addr, odp_pkg::ODP_FRAC1);
	wire wr_crs = reg_wr & in_band(reg_addr, odp_pkg::ODP_COARSE);
	wire wr_fine = reg_wr & (reg_addr[15:1] == odp_pkg::ODP_FINE[15:1]);
	wire wr_mode = reg_wr & (reg_addr == odp_pkg::ODP_MODE);
	wire wr_rs = reg_wr & (reg_addr == odp_pkg::ODP_RESYNC);
	wire [1:0] rs_tog = wr_rs ? (reg_wdata[1:0] ^ output_resync_trigger)
		: 2'b00;
	wire [1:0] lol_rise = lol_s & ~lol_d;
	wire [1:0] lol_fall = ~lol_s & lol_d;
	wire [1:0] resync = rs_tog | lol_fall;
	wire [1:0] crs_clr = rs_tog | lol_rise;
	wire [6:0] src_tick = {xtal_tick, reference_input_b_tick,
		reference_input_a_tick, frac_edge, second_pll_tick, first_pll_tick};

	// register file writes
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < 8; i++) begin
				out_cfg[i] <= odp_pkg::ODP_RST_OUT_CFG;
				div_cfg[i] <= odp_pkg::ODP_RST_DIV_CFG;
				s2_lo[i] <= odp_pkg::ODP_RST_BYTE;
				s2_hi[i] <= odp_pkg::ODP_RST_BYTE;
				coarse[i] <= odp_pkg::ODP_RST_BYTE;
			end
			for (int f = 0; f < 2; f++) begin
				for (int b = 0; b < odp_pkg::ODP_FRAC_BYTES; b++)
					frac_b[f][b] <= (b == 0) ? odp_pkg::ODP_RST_N_LO
						: odp_pkg::ODP_RST_BYTE;
				fine[f] <= 4'h0;
			end
			mode_reg <= 6'h00;
			output_resync_trigger <= 2'b00;
		end else begin
			if (wr_out)
				out_cfg[idx] <= {4'h0, reg_wdata[3:0]};
			if (wr_div)
				div_cfg[idx] <= {6'h00, reg_wdata[1:0]};
			if (wr_s2l)
				s2_lo[idx] <= reg_wdata;
			if (wr_s2h)
				s2_hi[idx] <= reg_wdata;
			if (wr_f0 && idx < 3'h7)
				frac_b[0][idx] <= reg_wdata;
			if (wr_f1 && idx < 3'h7)
				frac_b[1][idx] <= reg_wdata;
			if (wr_crs)
				coarse[idx] <= {1'b0, reg_wdata[6:0]};
			if (wr_fine)
				fine[reg_addr[0]] <= reg_wdata[3:0];
			if (wr_mode)
				mode_reg <= reg_wdata[5:0];
			if (wr_rs)
				output_resync_trigger <= reg_wdata[1:0];
		end
	end

	// lock flags come from the pll domain: two-flop sync, then edge
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			lol_m <= 2'b11;
			lol_s <= 2'b11;
			lol_d <= 2'b11;
		end else begin
			lol_m <= loss_of_lock_flag;
			lol_s <= lol_m;
			lol_d <= lol_s;
		end
	end

	// per-pll settling window after relock or resync
	generate
	for (genvar p = 0; p < 2; p++) begin : g_pll
		always_ff @(posedge clk or negedge rst_b) begin
			if (!rst_b)
				settle[p] <= 5'h00;
			else if (resync[p])
				settle[p] <= odp_pkg::ODP_SETTLE_LOAD;
			else if (settle[p] != 5'h00)
				settle[p] <= settle[p] - 5'h01;
		end
		// lol_d covers the edge-detect cycle before the window loads
		assign output_settling[p] = (settle[p] != 5'h00) | lol_s[p] | lol_d[p];
		// hitless withheld under external loopback
		assign hitless_active[p] = mode_reg[p] & ~ext_loopback;
	end
	endgenerate
	assign phase_slope_rate = mode_reg[5:2];

	// per-output source, divider, coarse engine and inversion
	generate
	for (genvar i = 0; i < 8; i++) begin : g_out
		localparam bit FRAC = (i == 2) || (i == 3);
		localparam bit UPPER = (i >= 4);
		logic [4:0] left;
		logic [1:0] gap;
		wire [2:0] src = UPPER ? out_cfg[i][2:0]
			: {2'b00, out_cfg[i][0]};
		wire [1:0] own = src_pll(src, out_cfg[2][0], out_cfg[3][0]);
		wire tick = (src <= odp_pkg::ODP_SRC_XTAL) ? src_tick[src] : 1'b0;
		wire nocrs = UPPER && div_cfg[i][1:0] == odp_pkg::ODP_S1_PASS;
		wire trig = wr_crs && idx == 3'(i) &&
			reg_wdata[odp_pkg::ODP_TRIG_BIT] !=
			coarse[i][odp_pkg::ODP_TRIG_BIT];
		wire clr = own[1] & crs_clr[own[0]];
		// restart of frac source also realigns its users
		assign restart[i] = own[1] & resync[own[0]];

		// coarse stepping: stretch now, then every four periods
		always_ff @(posedge clk or negedge rst_b) begin
			if (!rst_b) begin
				busy[i] <= 1'b0;
				left <= 5'h00;
				gap <= 2'h0;
				stretch[i] <= 1'b0;
			end else begin
				stretch[i] <= 1'b0;
				if (clr) begin
					busy[i] <= 1'b0;
				end else if (!busy[i]) begin
					// busy ignores toggles; bypass has no coarse
					if (trig && !nocrs &&
						reg_wdata[4:0] != 5'h00) begin
						busy[i] <= 1'b1;
						left <= reg_wdata[4:0];
						gap <= 2'h0;
						stretch[i] <= 1'b1;
					end
				end else if (rise[i]) begin
					if (gap == odp_pkg::ODP_STEP_GAP) begin
						gap <= 2'h0;
						if (left == 5'h01) begin
							busy[i] <= 1'b0;
						end else begin
							left <= left - 5'h01;
							stretch[i] <= 1'b1;
						end
					end else begin
						gap <= gap + 2'h1;
					end
				end
			end
		end

		if (FRAC) begin : g_frac
			localparam int F = i - 2;
			logic [17:0] fcnt;
			logic [27:0] facc;
			logic extra, flvl, skip, fprev;
			wire [17:0] n_raw = {frac_b[F][2][1:0], frac_b[F][1],
				frac_b[F][0]};
			wire [27:0] f_raw = {frac_b[F][6][3:0], frac_b[F][5],
				frac_b[F][4], frac_b[F][3]};
			// n of three only legal with zero fraction
			wire n_ok = (n_raw >= odp_pkg::ODP_N_MIN) ||
				(n_raw == odp_pkg::ODP_N_INT_MIN && f_raw == 28'h0);
			wire [17:0] n_eff = n_ok ? n_raw : odp_pkg::ODP_N_MIN;
			wire [17:0] limit = n_eff - 18'h1 + {17'h0, extra};
			wire [28:0] acc_sum = {1'b0, facc} + {1'b0, f_raw};
			wire eff = tick & ~skip;
			wire wrap = eff && fcnt >= limit;
			// half period of n.f steps: ratio twice n.f
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					fcnt <= 18'h0;
					facc <= 28'h0;
					extra <= 1'b0;
					flvl <= 1'b0;
					skip <= 1'b0;
				end else if (restart[i]) begin
					// phase after resync set only by fine offset
					fcnt <= 18'h0;
					facc <= {fine[F], 24'h0};
					extra <= 1'b0;
					flvl <= 1'b0;
					skip <= 1'b0;
				end else begin
					if (stretch[i])
						skip <= 1'b1;
					else if (tick)
						skip <= 1'b0;
					if (wrap) begin
						fcnt <= 18'h0;
						flvl <= ~flvl;
						facc <= acc_sum[27:0];
						extra <= acc_sum[28];
					end else if (eff) begin
						fcnt <= fcnt + 18'h1;
					end
				end
			end
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					fprev <= 1'b0;
					frac_edge[F] <= 1'b0;
				end else begin
					fprev <= flvl;
					frac_edge[F] <= flvl & ~fprev;
				end
			end
			assign lvl[i] = flvl;
			assign rise[i] = frac_edge[F];
		end else begin : g_int
			// pass-through first stage only on upper outputs
			wire [1:0] s1 = (!UPPER && div_cfg[i][1:0] ==
				odp_pkg::ODP_S1_PASS) ? odp_pkg::ODP_S1_DIV4
				: div_cfg[i][1:0];
			odp_int_div u_div (
				.clk(clk),
				.rst_b(rst_b),
				.tick(tick),
				.restart(restart[i]),
				.stretch(stretch[i]),
				.s1_sel(s1),
				.s2_half({s2_hi[i], s2_lo[i]}),
				.lvl(lvl[i]),
				.rise(rise[i])
			);
		end

		// inversion gives half-period shift
		always_ff @(posedge clk or negedge rst_b) begin
			if (!rst_b)
				out_clk[i] <= 1'b0;
			else
				out_clk[i] <= lvl[i] ^ out_cfg[i][odp_pkg::ODP_INV_BIT];
		end
	end
	endgenerate

	// read decode, reserved space reads zero
	always_comb begin
		rd_val = 8'h00;
		if (in_band(reg_addr, odp_pkg::ODP_OUT_CFG))
			rd_val = out_cfg[idx];
		else if (in_band(reg_addr, odp_pkg::ODP_DIV_CFG))
			rd_val = div_cfg[idx];
		else if (in_band(reg_addr, odp_pkg::ODP_S2_LO))
			rd_val = s2_lo[idx];
		else if (in_band(reg_addr, odp_pkg::ODP_S2_HI))
			rd_val = s2_hi[idx];
		else if (in_band(reg_addr, odp_pkg::ODP_FRAC0) && idx < 3'h7)
			rd_val = frac_b[0][idx];
		else if (in_band(reg_addr, odp_pkg::ODP_FRAC1) && idx < 3'h7)
			rd_val = frac_b[1][idx];
		else if (in_band(reg_addr, odp_pkg::ODP_COARSE))
			rd_val = {busy[idx], coarse[idx][6:0]};
		else if (reg_addr[15:1] == odp_pkg::ODP_FINE[15:1])
			rd_val = {4'h0, fine[reg_addr[0]]};
		else if (reg_addr == odp_pkg::ODP_MODE)
			rd_val = {2'b00, mode_reg};
		else if (reg_addr == odp_pkg::ODP_RESYNC)
			rd_val = {6'h00, output_resync_trigger};
	end

	// read data registered one cycle after address
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			reg_rdata <= 8'h00;
		else
			reg_rdata <= rd_val;
	end
endmodule // odp_top
`default_nettype wire

// File: verification/odp_top_monitor.sv
// port checker for mode, read, resync and settle behaviour
`timescale 1ns/1ps
`default_nettype none
module odp_top_monitor (
	input wire logic clk, // system clock
	input wire logic rst_b, // reset, active low
	input wire logic [15:0] reg_addr, // register address
	input wire logic [7:0] reg_wdata, // write data
	input wire logic reg_wr, // write strobe
	input wire logic [7:0] reg_rdata, // read data
	input wire logic [1:0] loss_of_lock_flag, // per pll unlock
	input wire logic ext_loopback, // loopback in use
	input wire logic [1:0] hitless_active, // hitless in force
	input wire logic [3:0] phase_slope_rate, // slope rates
	input wire logic [1:0] output_settling // outputs unstable
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	logic [7:0] mode;
	logic [1:0] rs;
	logic [4:0] quiet;
	// write decode for shadowed registers
	wire logic wr_mode = reg_wr && reg_addr == 16'h003c;
	wire logic wr_rs = reg_wr && reg_addr == 16'h00a8;
	wire logic tog0 = wr_rs && reg_wdata[0] != rs[0];
	// shadows and quiet span since last first pll disturbance
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mode <= 8'h00;
			rs <= 2'h0;
			quiet <= 5'h00;
		end else begin
			if (wr_mode) mode <= reg_wdata;
			if (wr_rs) rs <= reg_wdata[1:0];
			if (loss_of_lock_flag[0] || tog0) quiet <= 5'h00;
			else if (quiet != 5'h1f) quiet <= quiet + 5'h01;
		end
	end
	a_hitless_gated: assert property (
		hitless_active == (mode[1:0] & {2{!ext_loopback}}))
		else $error("hitless flag does not follow mode and loopback");
	a_slope_rate: assert property (phase_slope_rate == mode[5:2])
		else $error("slope rate does not follow mode register");
	a_mode_readback: assert property (
		reg_addr == 16'h003c && !reg_wr |=> reg_rdata[5:0] == mode[5:0])
		else $error("mode register read back wrong");
	a_unmapped_zero: assert property (
		reg_addr[15:8] != 8'h00 |=> reg_rdata == 8'h00)
		else $error("unmapped address reads nonzero");
	a_unlock_settle: assert property (
		loss_of_lock_flag[0] [*3] |-> output_settling[0])
		else $error("unlock not flagged as settling");
	a_unlock_b_settle: assert property (
		$rose(loss_of_lock_flag[1]) |-> ##[2:3] output_settling[1])
		else $error("second pll unlock not flagged");
	a_resync_settle: assert property (tog0 |-> ##[1:2] output_settling[0])
		else $error("resync toggle not flagged as settling");
	a_settle_ends: assert property (quiet >= 5'h18 |-> !output_settling[0])
		else $error("settling window too long");
	c_resync: cover property (tog0);
	c_settle_end: cover property ($fell(output_settling[0]));
	c_hitless: cover property (hitless_active[0]);
endmodule // odp_top_monitor
bind odp_top odp_top_monitor i_odp_top_monitor (.clk(clk), .rst_b(rst_b),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rdata(reg_rdata), .loss_of_lock_flag(loss_of_lock_flag),
	.ext_loopback(ext_loopback), .hitless_active(hitless_active),
	.phase_slope_rate(phase_slope_rate), .output_settling(output_settling));
`default_nettype wire

// File: verification/odp_load_model.sv
// clock load model: span between rising edges of each output
`timescale 1ns/1ps
`default_nettype none
module odp_load_model (
	input wire logic clk, // system clock
	input wire logic rst_b, // reset, active low
	input wire logic [7:0] out_clk, // loaded output clocks
	output logic [7:0][15:0] period, // last rise to rise span
	output logic [7:0][15:0] nrise // rising edges seen
);
	logic [7:0] prev;
	logic [7:0][15:0] cnt;
	// edge detect and span count per output
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			prev <= 8'h00;
			cnt <= '0;
			period <= '0;
			nrise <= '0;
		end else begin
			prev <= out_clk;
			for (int i = 0; i < 8; i++) begin
				if (out_clk[i] && !prev[i]) begin
					period[i] <= cnt[i];
					cnt[i] <= 16'h0001;
					nrise[i] <= nrise[i] + 16'h0001;
				end else cnt[i] <= cnt[i] + 16'h0001;
			end
		end
	end
endmodule // odp_load_model
`default_nettype wire

// File: verification/odp_top_tb.sv
// self-checking bench for the output divider block
`timescale 1ns/1ps
`default_nettype none
module odp_top_tb;
	logic clk, rst_b, reg_wr, ext_loopback;
	logic [15:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, out_clk, rd, d;
	logic [4:0] tick;
	logic [1:0] loss_of_lock_flag, hitless_active, output_settling, rs;
	logic [3:0] phase_slope_rate;
	logic [7:0][15:0] period, nrise;
	int n_mismatch, n_compared, t;
	odp_top i_odp_top (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
		.first_pll_tick(tick[0]), .second_pll_tick(tick[1]),
		.reference_input_a_tick(tick[2]), .reference_input_b_tick(tick[3]),
		.xtal_tick(tick[4]), .loss_of_lock_flag(loss_of_lock_flag),
		.ext_loopback(ext_loopback), .out_clk(out_clk),
		.hitless_active(hitless_active), .phase_slope_rate(phase_slope_rate),
		.output_settling(output_settling));
	odp_load_model i_odp_load_model (.clk(clk), .rst_b(rst_b),
		.out_clk(out_clk), .period(period), .nrise(nrise));
	task automatic chk(input string what, input logic [15:0] exp, got);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		@(posedge clk);
		#1 reg_addr = a;
		reg_wdata = v;
		reg_wr = 1'b1;
		@(posedge clk);
		#1 reg_wr = 1'b0;
	endtask
	task automatic rd8(input logic [15:0] a);
		@(posedge clk);
		#1 reg_addr = a;
		@(posedge clk);
		#1 rd = reg_rdata;
	endtask
	task automatic resync(input int p);
		rs[p] = ~rs[p];
		wr(16'h00a8, {6'h00, rs});
	endtask
	task automatic settle(input int o, input int n);
		logic [15:0] s;
		s = nrise[o];
		for (int k = 0; k < 9000 && nrise[o] < s + n; k++) @(posedge clk);
		#1;
		if (nrise[o] < s + n) begin
			n_mismatch++;
			$display("[FAIL] edges on output %0d expected %0d seen %0d", o, n,
				nrise[o] - s);
		end
	endtask
	task automatic cfg(input int o, input logic [7:0] src, s1, lo);
		wr(16'(o), src);
		wr(16'h0008 + 16'(o), s1);
		wr(16'h0010 + 16'(o), lo);
		wr(16'h0018 + 16'(o), 8'h00);
	endtask
	task automatic t_regs;
		rd8(16'h003c);
		chk("mode reset", 16'h0000, {8'h00, rd});
		rd8(16'h0020);
		chk("n reset", {8'h00, odp_pkg::ODP_RST_N_LO}, {8'h00, rd});
		wr(16'h0200, 8'h5a);
		rd8(16'h0200);
		chk("unmapped", 16'h0000, {8'h00, rd});
		wr(16'h0039, 8'h0a);
		rd8(16'h0039);
		chk("fine", 16'h000a, {8'h00, rd});
		$display("test regs done");
	endtask
	task automatic t_mode;
		for (int k = 0; k < 8; k++) begin
			d = 8'(k / 2 * 21);
			wr(16'h003c, d);
			ext_loopback = k[0];
			#1 chk("hitless", {14'h0, d[1:0] & {2{~k[0]}}}, {14'h0, hitless_active});
			chk("slope", {12'h0, d[5:2]}, {12'h0, phase_slope_rate});
		end
		ext_loopback = 1'b0;
		$display("test mode done");
	endtask
	task automatic t_div;
		for (int a = 0; a < 3; a++)
			for (int b = 0; b < 3; b++) begin
				cfg(0, 8'h00, 8'(a), 8'(b));
				resync(0);
				settle(0, 3);
				chk("int period", 16'((4 + a) * (b == 0 ? 1 : 2 * b)), period[0]);
			end
		cfg(0, 8'h00, 8'h00, 8'h00);
		wr(16'h0018, 8'h01);
		resync(0);
		settle(0, 3);
		chk("high half", 16'h0800, period[0]);
		cfg(5, 8'h01, 8'h03, 8'h02);
		resync(1);
		settle(5, 3);
		chk("pass first", 16'h0008, period[5]);
		$display("test div done");
	endtask
	task automatic t_frac;
		cfg(2, 8'h00, 8'h00, 8'h00);
		cfg(4, 8'h02, 8'h03, 8'h01);
		for (int k = 0; k < 3; k++) begin
			wr(16'h0020, 8'(k + 2));
			resync(0);
			settle(2, 3);
			settle(4, 3);
			chk("frac period", k == 0 ? 16'h0008 : 16'(2 * (k + 2)), period[2]);
			chk("frac fed", {period[2][14:0], 1'b0}, period[4]);
		end
		cfg(3, 8'h01, 8'h00, 8'h00);
		resync(1);
		settle(3, 3);
		chk("frac second pll", 16'h0010, period[3]);
		$display("test frac done");
	endtask
	task automatic t_inv;
		cfg(0, 8'h00, 8'h00, 8'h01);
		cfg(1, 8'h08, 8'h00, 8'h01);
		resync(0);
		settle(0, 2);
		for (int k = 0; k < 16; k++) begin
			@(posedge clk);
			#1 chk("inverted", {15'h0, ~out_clk[0]}, {15'h0, out_clk[1]});
		end
		$display("test inv done");
	endtask
	task automatic t_coarse;
		wr(16'h0030, 8'h43);
		rd8(16'h0030);
		chk("busy", 16'h0001, {15'h0, rd[7]});
		wr(16'h0030, 8'h03);
		for (t = 0; t < 300 && rd[7] !== 1'b0; t++) rd8(16'h0030);
		chk("coarse span", 16'h0001, 16'(t >= 25 && t <= 65));
		wr(16'h0030, 8'h5f);
		rd8(16'h0030);
		chk("busy max", 16'h0001, {15'h0, rd[7]});
		resync(0);
		rd8(16'h0030);
		chk("resync clears", 16'h0000, {15'h0, rd[7]});
		rd8(16'h00a8);
		chk("resync reg", {14'h0, rs}, {14'h0, rd[1:0]});
		wr(16'h0035, 8'h41);
		rd8(16'h0035);
		chk("bypass no coarse", 16'h0000, {15'h0, rd[7]});
		$display("test coarse done");
	endtask
	task automatic t_lol;
		wr(16'h0030, 8'h1f);
		loss_of_lock_flag = 2'h3;
		repeat (6) @(posedge clk);
		#1 chk("unlocked", 16'h0003, {14'h0, output_settling});
		loss_of_lock_flag = 2'h0;
		for (t = 0; t < 40 && output_settling[0] !== 1'b0; t++) begin
			@(posedge clk);
			#1;
		end
		chk("settle span", 16'h0001, 16'(t >= 18 && t <= 24));
		rd8(16'h0030);
		chk("relock clears", 16'h0000, {15'h0, rd[7]});
		$display("test lol done");
	endtask
	task automatic summarize;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// reset, then the scenarios
	initial begin
		rst_b = 1'b0;
		reg_wr = 1'b0;
		reg_addr = 16'h0000;
		reg_wdata = 8'h00;
		tick = 5'h1f;
		loss_of_lock_flag = 2'h3;
		ext_loopback = 1'b0;
		rs = 2'h0;
		repeat (12) @(posedge clk);
		#1 rst_b = 1'b1;
		loss_of_lock_flag = 2'h0;
		t_regs;
		t_mode;
		t_div;
		t_frac;
		t_inv;
		t_coarse;
		t_lol;
		summarize;
	end
	// second pll steps at half rate so the two plls differ
	initial forever begin
		@(posedge clk);
		#1 tick[1] = ~tick[1];
	end
	// watchdog
	initial begin
		repeat (40000) @(posedge clk);
		n_mismatch++;
		summarize;
	end
endmodule // odp_top_tb
`default_nettype wire
